/* File: core/hpm_pkg.sv */
package hpm_pkg;
    // widths
    localparam int unsigned WORD_W = 16;
    localparam int unsigned CPU_ADDR_W = 16;
    localparam int unsigned HOST_ADDR_W = 2;
    localparam int unsigned ENG_W = 8;

    // cpu side addresses
    localparam logic [15:0] CPU_MAILBOX_ADDR = 16'hC0C6;
    localparam logic [15:0] CPU_ENG1_MSG_ADDR = 16'h0144;
    localparam logic [15:0] CPU_ENG2_MSG_ADDR = 16'h0148;

    // host port address codes
    localparam logic [1:0] HOST_MAILBOX_SEL = 2'h0;
    localparam logic [1:0] HOST_STATUS_SEL = 2'h3;

    // reset values
    localparam logic [15:0] MAILBOX_RST = 16'h0000;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    // status word bit positions
    localparam int unsigned ST_VBUS = 15;
    localparam int unsigned ST_ID = 14;
    localparam int unsigned ST_RSVD_HI = 13;
    localparam int unsigned ST_FRAME2 = 12;
    localparam int unsigned ST_RSVD_LO = 11;
    localparam int unsigned ST_FRAME1 = 10;
    localparam int unsigned ST_BUSRST2 = 9;
    localparam int unsigned ST_MBX_IN = 8;
    localparam int unsigned ST_RESUME2 = 7;
    localparam int unsigned ST_RESUME1 = 6;
    localparam int unsigned ST_ENG2_MSG = 5;
    localparam int unsigned ST_ENG1_MSG = 4;
    localparam int unsigned ST_DONE2 = 3;
    localparam int unsigned ST_DONE1 = 2;
    localparam int unsigned ST_BUSRST1 = 1;
    localparam int unsigned ST_MBX_OUT = 0;

    // routing register bit positions
    localparam int unsigned RT_FRAME2 = 13;
    localparam int unsigned RT_FRAME1 = 11;
    localparam int unsigned RT_BUSRST2 = 9;
    localparam int unsigned RT_RESUME2 = 7;
    localparam int unsigned RT_RESUME1 = 6;
    localparam int unsigned RT_DONE2 = 3;
    localparam int unsigned RT_DONE1 = 2;
    localparam int unsigned RT_BUSRST1 = 1;

    // engine flag input positions
    localparam int unsigned EF_FRAME2 = 7;
    localparam int unsigned EF_FRAME1 = 6;
    localparam int unsigned EF_BUSRST2 = 5;
    localparam int unsigned EF_BUSRST1 = 4;
    localparam int unsigned EF_RESUME2 = 3;
    localparam int unsigned EF_RESUME1 = 2;
    localparam int unsigned EF_DONE2 = 1;
    localparam int unsigned EF_DONE1 = 0;

    // supply settle time before status bit 15 is trusted, firmware side
    localparam int unsigned VBUS_SETTLE_NS = 10000;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned VBUS_SETTLE_CYC = (VBUS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: core/hpm_flag.sv */
`timescale 1ns/1ns
// sticky flag, set beats clear
module hpm_flag (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // events
    input wire logic set_i,
    input wire logic clr_i,
    // state
    output logic flag_o
);
    typedef struct packed {
        logic flag;
    } hpm_flag_st_t;

    hpm_flag_st_t st_q;
    hpm_flag_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (set_i) begin
            st_d.flag = 1'b1;
        end else if (clr_i) begin
            st_d.flag = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag_o = st_q.flag;
endmodule // hpm_flag

/* File: core/hpm_host_port_mailbox.sv */
`timescale 1ns/1ns
// Function
// - host mailbox write raises enabled rx-full irq
// - cpu mailbox read clears rx-full
// - host mailbox read raises enabled tx-empty irq
// - cpu mailbox write clears tx-empty
// - cpu mailbox write asserts host irq
// - host mailbox read drops that host irq
// - mailbox holds full 16-bit word
// - status word readable by host only
// - status reads start no memory cycle
// - bit 15 shows supply above threshold
// - bit 14 shows id pin level
// - bits 12,10 show frame events
// - bits 9,1 show bus reset events
// - bits 7,6 show resume events
// - bit 8 incoming message waits
// - bit 0 outgoing message waits
// - bits 5,4 engine message flags
// - bits 3,2 show packet-done per port
// - routed engine flags reach host port
// - any engine message write sets flag
module hpm_host_port_mailbox
    import hpm_pkg::*;
#(
    parameter int unsigned DATA_W = hpm_pkg::WORD_W
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // on-chip cpu register access
    input wire logic [hpm_pkg::CPU_ADDR_W-1:0] CPU_ADDR,
    input wire logic CPU_WR,
    input wire logic CPU_RD,
    input wire logic [DATA_W-1:0] CPU_WDATA,
    output logic [DATA_W-1:0] CPU_RDATA,
    // mailbox interrupt enables and requests
    input wire logic MBX_RX_FULL_IE,
    input wire logic MBX_TX_EMPTY_IE,
    output logic MBX_RX_FULL_IRQ,
    output logic MBX_TX_EMPTY_IRQ,
    // external host port
    input wire logic [hpm_pkg::HOST_ADDR_W-1:0] HOST_ADDR,
    input wire logic HOST_WR,
    input wire logic HOST_RD,
    input wire logic [DATA_W-1:0] HOST_WDATA,
    output logic [DATA_W-1:0] HOST_RDATA,
    output logic HOST_PORT_IRQ_OUT,
    // host mailbox access forwarded to cpu memory arbiter
    output logic HOST_MEM_CYCLE,
    // routing, engine events and otg levels
    input wire logic [15:0] ROUTE_EN,
    input wire logic [hpm_pkg::ENG_W-1:0] ENG_FLAGS,
    input wire logic ENG1_MSG_IE,
    input wire logic ENG2_MSG_IE,
    input wire logic VBUS_VALID,
    input wire logic OTG_ID
);
    import hpm_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] mailbox;
        logic [DATA_W-1:0] host_rdata;
        logic [DATA_W-1:0] cpu_rdata;
        logic mem_cycle;
    } hpm_st_t;

    hpm_st_t st_q;
    hpm_st_t st_d;

    logic host_mbx_wr;
    logic host_mbx_rd;
    logic host_st_rd;
    logic cpu_mbx_wr;
    logic cpu_mbx_rd;
    logic eng1_wr;
    logic eng2_wr;
    logic mbx_in;
    logic mbx_out;
    logic tx_empty;
    logic eng1_msg;
    logic eng2_msg;
    logic [ENG_W-1:0] eng_routed;
    logic [15:0] status_word;

    function automatic logic routed(input logic [15:0] rt, input int unsigned rb,
                                    input logic [ENG_W-1:0] ef, input int unsigned eb);
        routed = rt[rb] & ef[eb];
    endfunction

    assign host_mbx_wr = HOST_WR && (HOST_ADDR == HOST_MAILBOX_SEL);
    assign host_mbx_rd = HOST_RD && (HOST_ADDR == HOST_MAILBOX_SEL);
    assign host_st_rd = HOST_RD && (HOST_ADDR == HOST_STATUS_SEL);
    assign cpu_mbx_wr = CPU_WR && (CPU_ADDR == CPU_MAILBOX_ADDR);
    assign cpu_mbx_rd = CPU_RD && (CPU_ADDR == CPU_MAILBOX_ADDR);
    assign eng1_wr = CPU_WR && (CPU_ADDR == CPU_ENG1_MSG_ADDR);
    assign eng2_wr = CPU_WR && (CPU_ADDR == CPU_ENG2_MSG_ADDR);

    hpm_flag u_mbx_in (
        .REF_CLK(REF_CLK),
        .RESETN(RESETN),
        .set_i(host_mbx_wr),
        .clr_i(cpu_mbx_rd),
        .flag_o(mbx_in)
    );

    hpm_flag u_mbx_out (
        .REF_CLK(REF_CLK),
        .RESETN(RESETN),
        .set_i(cpu_mbx_wr),
        .clr_i(host_mbx_rd),
        .flag_o(mbx_out)
    );

    hpm_flag u_tx_empty (
        .REF_CLK(REF_CLK),
        .RESETN(RESETN),
        .set_i(host_mbx_rd),
        .clr_i(cpu_mbx_wr),
        .flag_o(tx_empty)
    );

    hpm_flag u_eng1_msg (
        .REF_CLK(REF_CLK),
        .RESETN(RESETN),
        .set_i(eng1_wr),
        .clr_i(HOST_RD),
        .flag_o(eng1_msg)
    );

    hpm_flag u_eng2_msg (
        .REF_CLK(REF_CLK),
        .RESETN(RESETN),
        .set_i(eng2_wr),
        .clr_i(HOST_RD),
        .flag_o(eng2_msg)
    );

    always_comb begin
        eng_routed = '0;
        eng_routed[EF_FRAME2] = routed(ROUTE_EN, RT_FRAME2, ENG_FLAGS, EF_FRAME2);
        eng_routed[EF_FRAME1] = routed(ROUTE_EN, RT_FRAME1, ENG_FLAGS, EF_FRAME1);
        eng_routed[EF_BUSRST2] = routed(ROUTE_EN, RT_BUSRST2, ENG_FLAGS, EF_BUSRST2);
        eng_routed[EF_BUSRST1] = routed(ROUTE_EN, RT_BUSRST1, ENG_FLAGS, EF_BUSRST1);
        eng_routed[EF_RESUME2] = routed(ROUTE_EN, RT_RESUME2, ENG_FLAGS, EF_RESUME2);
        eng_routed[EF_RESUME1] = routed(ROUTE_EN, RT_RESUME1, ENG_FLAGS, EF_RESUME1);
        eng_routed[EF_DONE2] = routed(ROUTE_EN, RT_DONE2, ENG_FLAGS, EF_DONE2);
        eng_routed[EF_DONE1] = routed(ROUTE_EN, RT_DONE1, ENG_FLAGS, EF_DONE1);
    end

    // status word assembly
    always_comb begin
        status_word = ZERO_WORD;
        status_word[ST_VBUS] = VBUS_VALID;
        status_word[ST_ID] = OTG_ID;
        status_word[ST_RSVD_HI] = 1'b0;
        status_word[ST_RSVD_LO] = 1'b0;
        status_word[ST_FRAME2] = eng_routed[EF_FRAME2];
        status_word[ST_FRAME1] = eng_routed[EF_FRAME1];
        status_word[ST_BUSRST2] = eng_routed[EF_BUSRST2];
        status_word[ST_BUSRST1] = eng_routed[EF_BUSRST1];
        status_word[ST_RESUME2] = eng_routed[EF_RESUME2];
        status_word[ST_RESUME1] = eng_routed[EF_RESUME1];
        status_word[ST_DONE2] = eng_routed[EF_DONE2];
        status_word[ST_DONE1] = eng_routed[EF_DONE1];
        status_word[ST_MBX_IN] = mbx_in;
        status_word[ST_MBX_OUT] = mbx_out;
        status_word[ST_ENG2_MSG] = eng2_msg;
        status_word[ST_ENG1_MSG] = eng1_msg;
    end

    always_comb begin
        st_d = st_q;
        st_d.mem_cycle = 1'b0;
        // full word store, host write wins a tie
        if (host_mbx_wr) begin
            st_d.mailbox = HOST_WDATA;
        end else if (cpu_mbx_wr) begin
            st_d.mailbox = CPU_WDATA;
        end
        // only mailbox accesses use memory cycles
        if (host_mbx_wr || host_mbx_rd) begin
            st_d.mem_cycle = 1'b1;
        end
        if (host_mbx_rd) begin
            st_d.host_rdata = st_q.mailbox;
        end else if (host_st_rd) begin
            st_d.host_rdata = status_word;
        end
        // cpu sees mailbox only, never status
        if (cpu_mbx_rd) begin
            st_d.cpu_rdata = st_q.mailbox;
        end else if (CPU_RD) begin
            st_d.cpu_rdata = ZERO_WORD;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            st_q.mailbox <= MAILBOX_RST;
            st_q.host_rdata <= ZERO_WORD;
            st_q.cpu_rdata <= ZERO_WORD;
            st_q.mem_cycle <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign CPU_RDATA = st_q.cpu_rdata;
    assign HOST_RDATA = st_q.host_rdata;
    assign HOST_MEM_CYCLE = st_q.mem_cycle;
    assign MBX_RX_FULL_IRQ = mbx_in & MBX_RX_FULL_IE;
    assign MBX_TX_EMPTY_IRQ = tx_empty & MBX_TX_EMPTY_IE;
    assign HOST_PORT_IRQ_OUT = mbx_out | (|eng_routed) | (eng1_msg & ENG1_MSG_IE) | (eng2_msg & ENG2_MSG_IE);
endmodule // hpm_host_port_mailbox

/* File: test/hpm_chk.sv */
`timescale 1ns/1ns
module hpm_chk (
    // watched ports
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic [15:0] CPU_ADDR,
    input wire logic CPU_WR,
    input wire logic CPU_RD,
    input wire logic [15:0] CPU_RDATA,
    input wire logic MBX_RX_FULL_IE,
    input wire logic MBX_TX_EMPTY_IE,
    input wire logic MBX_RX_FULL_IRQ,
    input wire logic MBX_TX_EMPTY_IRQ,
    input wire logic [1:0] HOST_ADDR,
    input wire logic HOST_WR,
    input wire logic HOST_RD,
    input wire logic [15:0] HOST_WDATA,
    input wire logic [15:0] HOST_RDATA,
    input wire logic HOST_PORT_IRQ_OUT,
    input wire logic HOST_MEM_CYCLE,
    input wire logic [15:0] ROUTE_EN,
    input wire logic [7:0] ENG_FLAGS,
    input wire logic VBUS_VALID,
    input wire logic OTG_ID
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    wire logic hm = HOST_ADDR == 2'h0;
    wire logic cm = CPU_ADDR == 16'hC0C6;
    wire logic [7:0] rt = {ROUTE_EN[13], ROUTE_EN[11], ROUTE_EN[9], ROUTE_EN[1],
        ROUTE_EN[7], ROUTE_EN[6], ROUTE_EN[3], ROUTE_EN[2]};
    wire logic eng = |(ENG_FLAGS & rt);
    sequence s_put;
        HOST_WR && hm ##1 !HOST_WR && !CPU_WR;
    endsequence
    sequence s_take;
        CPU_RD && cm && !HOST_WR && !CPU_WR;
    endsequence
    a_rx_set: assert property (HOST_WR && hm |=> MBX_RX_FULL_IRQ || !MBX_RX_FULL_IE)
        else $error("rx set");
    a_rx_clear: assert property (CPU_RD && cm && !(HOST_WR && hm) |=> !MBX_RX_FULL_IRQ)
        else $error("rx clear");
    a_tx_set: assert property (HOST_RD && hm |=> MBX_TX_EMPTY_IRQ || !MBX_TX_EMPTY_IE)
        else $error("tx set");
    a_tx_clear: assert property (CPU_WR && cm && !(HOST_RD && hm) |=> !MBX_TX_EMPTY_IRQ)
        else $error("tx clear");
    a_irq_set: assert property (CPU_WR && cm |=> HOST_PORT_IRQ_OUT)
        else $error("irq set");
    a_irq_drop: assert property (HOST_RD && hm && !CPU_WR |=> HOST_PORT_IRQ_OUT == eng)
        else $error("irq drop");
    a_irq_routed: assert property (eng |-> HOST_PORT_IRQ_OUT)
        else $error("routed");
    a_mail_word: assert property (s_put ##1 s_take |=> CPU_RDATA == $past(HOST_WDATA, 3))
        else $error("word");
    a_mem_cycle: assert property ((HOST_WR || HOST_RD) |=> HOST_MEM_CYCLE == $past(hm))
        else $error("mem cycle");
    a_status_bits: assert property (HOST_RD && HOST_ADDR == 2'h3 |=>
        HOST_RDATA[15:14] == {$past(VBUS_VALID), $past(OTG_ID)} && !HOST_RDATA[13] && !HOST_RDATA[11])
        else $error("status");
endmodule // hpm_chk
bind hpm_host_port_mailbox hpm_chk u_chk (.*);

/* File: test/hpm_host_model.sv */
`timescale 1ns/1ns
module hpm_host_model
    import hpm_pkg::*;
(
    // host port
    input wire logic REF_CLK,
    output logic [1:0] HOST_ADDR = 2'h1,
    output logic HOST_WR = 1'h0,
    output logic HOST_RD = 1'h0,
    output logic [15:0] HOST_WDATA = 16'hFFFF,
    input wire logic [15:0] HOST_RDATA
);
    task automatic host(input logic w, input logic [1:0] s, input logic [15:0] d, output logic [15:0] q);
        @(posedge REF_CLK);
        HOST_ADDR <= s;
        HOST_WDATA <= d;
        HOST_WR <= w;
        HOST_RD <= !w;
        @(posedge REF_CLK);
        HOST_WR <= 1'h0;
        HOST_RD <= 1'h0;
        HOST_WDATA <= ~d;
        #1 q = HOST_RDATA;
    endtask
    task automatic settle;
        repeat (VBUS_SETTLE_CYC) @(posedge REF_CLK);
    endtask
endmodule // hpm_host_model

/* File: test/hpm_host_port_mailbox_tb_top.sv */
`timescale 1ns/1ns
module hpm_host_port_mailbox_tb_top;
    import hpm_pkg::*;
    logic REF_CLK = 1'h0, RESETN = 1'h0, CPU_WR = 1'h0, CPU_RD = 1'h0, VBUS_VALID = 1'h0, OTG_ID = 1'h0;
    logic MBX_RX_FULL_IE = 1'h1, MBX_TX_EMPTY_IE = 1'h1, ENG1_MSG_IE = 1'h1, ENG2_MSG_IE = 1'h0;
    logic [15:0] CPU_ADDR = 16'h0000, CPU_WDATA = 16'h0000, ROUTE_EN = 16'h0000, rd;
    logic [15:0] CPU_RDATA, HOST_WDATA, HOST_RDATA;
    logic [7:0] ENG_FLAGS = 8'h00;
    logic [1:0] HOST_ADDR;
    logic MBX_RX_FULL_IRQ, MBX_TX_EMPTY_IRQ, HOST_WR, HOST_RD, HOST_PORT_IRQ_OUT, HOST_MEM_CYCLE;
    int error_cnt = 0, n_tests = 0;
    hpm_host_port_mailbox u_dut (.*);
    hpm_host_model u_host (.*);
    initial forever #10 REF_CLK = ~REF_CLK;
    function automatic logic [15:0] b(input logic x);
        return {15'h0000, x};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cpu(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge REF_CLK);
        CPU_ADDR <= a;
        CPU_WDATA <= d;
        CPU_WR <= w;
        CPU_RD <= !w;
        @(posedge REF_CLK);
        CPU_WR <= 1'h0;
        CPU_RD <= 1'h0;
        #1 rd = CPU_RDATA;
    endtask
    task automatic st(input logic [15:0] e);
        u_host.host(1'h0, 2'h3, 16'h0000, rd);
        chk("status", e, rd);
        chk("mem cycle", 16'h0000, b(HOST_MEM_CYCLE));
    endtask
    task automatic t_inbound;
        u_host.host(1'h1, 2'h0, 16'hA5C3, rd);
        chk("rx", 16'h0001, b(MBX_RX_FULL_IRQ));
        chk("mem cycle", 16'h0001, b(HOST_MEM_CYCLE));
        cpu(1'h0, CPU_MAILBOX_ADDR, 16'h0000);
        chk("mailbox", 16'hA5C3, rd);
        chk("rx clr", 16'h0000, b(MBX_RX_FULL_IRQ));
        cpu(1'h0, CPU_ENG1_MSG_ADDR, 16'h0000);
        chk("cpu other", 16'h0000, rd);
        u_host.host(1'h1, 2'h0, 16'h3C5A, rd);
        st(16'h0100);
        cpu(1'h0, CPU_MAILBOX_ADDR, 16'h0000);
        st(16'h0000);
    endtask
    task automatic t_outbound;
        cpu(1'h1, CPU_MAILBOX_ADDR, 16'h5AF0);
        chk("irq", 16'h0001, b(HOST_PORT_IRQ_OUT));
        st(16'h0001);
        u_host.host(1'h0, 2'h0, 16'h0000, rd);
        chk("host read", 16'h5AF0, rd);
        chk("irq clr", 16'h0000, b(HOST_PORT_IRQ_OUT));
        chk("tx", 16'h0001, b(MBX_TX_EMPTY_IRQ));
        cpu(1'h1, CPU_MAILBOX_ADDR, 16'h0000);
        chk("tx clr", 16'h0000, b(MBX_TX_EMPTY_IRQ));
        u_host.host(1'h0, 2'h0, 16'h0000, rd);
    endtask
    task automatic t_engmsg;
        cpu(1'h1, CPU_ENG1_MSG_ADDR, 16'h0000);
        chk("msg irq", 16'h0001, b(HOST_PORT_IRQ_OUT));
        st(16'h0010);
        st(16'h0000);
        cpu(1'h1, CPU_ENG2_MSG_ADDR, 16'hFFFF);
        chk("msg masked", 16'h0000, b(HOST_PORT_IRQ_OUT));
        st(16'h0020);
    endtask
    task automatic t_route;
        int rb[8] = '{2, 3, 6, 7, 1, 9, 11, 13};
        int sb[8] = '{2, 3, 6, 7, 1, 9, 10, 12};
        for (int i = 0; i < 8; i++) begin
            @(posedge REF_CLK);
            ENG_FLAGS <= 8'h01 << i;
            ROUTE_EN <= 16'h0001 << rb[i];
            st(16'h0001 << sb[i]);
            chk("routed", 16'h0001, b(HOST_PORT_IRQ_OUT));
            @(posedge REF_CLK);
            ROUTE_EN <= ~(16'h0001 << rb[i]);
            st(16'h0000);
            chk("unrouted", 16'h0000, b(HOST_PORT_IRQ_OUT));
        end
    endtask
    task automatic t_levels;
        @(posedge REF_CLK);
        VBUS_VALID <= 1'h1;
        OTG_ID <= 1'h1;
        u_host.settle();
        st(16'hC000);
        @(posedge REF_CLK);
        VBUS_VALID <= 1'h0;
        st(16'h4000);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge REF_CLK);
        RESETN <= 1'h1;
        t_inbound();
        t_outbound();
        t_engmsg();
        t_route();
        t_levels();
        close_out();
    end
    initial begin
        repeat (3000) @(posedge REF_CLK);
        error_cnt++;
        close_out();
    end
endmodule // hpm_host_port_mailbox_tb_top
